// File: hdl/dcis_pkg.sv
package dcis_pkg;
    // status select codes
    localparam logic [1:0] SEL_CKWD = 2'h0;
    localparam logic [1:0] SEL_MAIN = 2'h1;
    localparam logic [1:0] SEL_CWA = 2'h2;
    localparam logic [1:0] SEL_SEEK = 2'h3;
    // widths and reset values
    localparam int CKWD_W = 12;
    localparam int TCA_W = 9;
    localparam logic [11:0] CKWD_RESET = 12'h000;
    localparam logic [8:0] TCA_RESET = 9'h000;
    localparam logic [2:0] IEN_RESET = 3'h0;
    // checkword feedback taps, bits 0..3 and 11
    localparam logic [11:0] CKWD_TAPS = 12'h80f;
    // phase timing
    localparam int PHASE_NS = 100;
    localparam int CLK_NS = 100;
    localparam int PHASE_CYC = (PHASE_NS + CLK_NS - 1) / CLK_NS;
    // interrupt enable bit positions in the output word
    localparam int IEN_CLR_BIT = 1;
    localparam int IEN_LO_BIT = 2;
    // main status bit positions
    localparam int ST_INTR = 2;
    localparam int ST_ALARM = 5;
    localparam int ST_CKERR = 8;
    // operation qualifiers travel together
    typedef struct packed {
        logic rd_wr_cc;
        logic rd_wr_cmp_cc;
    } dcis_op_s;
    // drive-side error sources
    typedef struct packed {
        logic set_drive_seek;
        logic set_ctrl_seek;
        logic addr_error;
        logic storage_parity_in;
        logic protect_fault_in;
        logic lost_data;
    } dcis_err_s;
endpackage : dcis_pkg

// File: hdl/dcis_core.sv
`timescale 1ns/100ps
// Functional notes
// - enable-load strobe sets each enable stage whose data bit 2..4 is high
// - with data bit 1 high, enable stages with low data bit clear
// - with data bit 1 low, enable stages with low data bit hold
// - master clear clears all three enable stages
// - ready-not-busy sampled T1 then T2; edge with enable sets interrupt
// - end-of-operation with its enable sets interrupt
// - alarm edge pulse with alarm enable sets interrupt
// - error flop set by busy-not-ready, seek, address or end-of-sector errors
// - error flop clears when second alarm flop sets or master clear
// - set-alarm pulse sets alarm and, with end-of-operation enable, sets interrupt
// - seek errors set on strobes; parity, protect on word-count strobe end
// - twelve-bit checkword shifts per strobe, xor feedback into 0,1,2,3,11
// - serial input blocked while checkword itself is written
// - nonzero checkword at sampled T2 sets checkword error flop
// - address-checkword-zero shown when register is zero after address read
// - holding register copies checkword on load; cleared by master clear
// - cylinder enable then shifts read data into 9-bit register at T4
// - select 00 returns checkword in bits 0..11, zeros above
// - select 01 returns the main status word
// - select 10 returns current word address
// - select 11 returns seek flags, zeros, captured cylinder
// - drive inverted status only during channel read while selected
// - enable stages update at leading edge of the function strobe
// - sequencing uses four phases of 100 ns each
module dcis_core (
    input wire logic SYS_CLK,
    input wire logic RESETN,
    input wire logic CLK_EN,
    input wire logic MASTER_CLEAR,
    input wire logic ERROR_CLEAR,
    input wire logic FUNCTION_STROBE,
    input wire logic [15:0] OUT_WORD,
    input wire logic DISK_READY,
    input wire logic ON_CYLINDER,
    input wire logic CONTROLLER_BUSY,
    input wire logic EOP_MARK,
    input wire logic EOP_ENABLE,
    input wire logic END_OF_SECTOR,
    input wire logic TRANSFER_CONNECTED,
    input wire logic WORD_COUNT_STROBE,
    input wire dcis_pkg::dcis_err_s ERR_IN,
    input wire dcis_pkg::dcis_op_s OP,
    input wire logic CKWD_SHIFT,
    input wire logic CKWD_SERIAL_IN,
    input wire logic WRITE_CKWD,
    input wire logic SAMPLE_CKWD,
    input wire logic ADDR_CKWD_READ,
    input wire logic LOAD_CKWD_HOLD,
    input wire logic UPPER_CYL_TO_SHIFTER,
    input wire logic READ_DATA,
    input wire logic DATA_MISCOMPARE,
    input wire logic UNIT_PROTECTED,
    input wire logic SINGLE_DENSITY,
    input wire logic [15:0] CURRENT_WORD_ADDR,
    input wire logic [3:0] SEEK_DONE_OR_ERROR,
    input wire logic [1:0] STATUS_SEL,
    input wire logic CHANNEL_READ,
    input wire logic UNIT_SELECTED,
    output logic INTERRUPT,
    output logic ALARM,
    output logic SET_ALARM_PULSE,
    output logic ADDR_CKWD_ZERO,
    output logic [11:0] CKWD_HOLD,
    output logic [1:0] PHASE,
    output logic [15:0] CHAN_IN_N,
    output logic CHAN_IN_OE
);

    typedef enum logic [1:0] {PH_T1, PH_T2, PH_T3, PH_T4} dcis_phase_e;

    dcis_phase_e phase;
    logic [$clog2(dcis_pkg::PHASE_CYC + 1)-1:0] ph_cnt;
    logic [2:0] int_en;
    logic rdy1, rdy2, intr, alarm1, alarm2, err_ff, alarm;
    logic drv_seek, ctl_seek, prot_fault, stor_par, ck_err, lost_seen;
    logic [11:0] ckwd, ckwd_hold;
    logic [8:0] true_cylinder_addr;
    logic tca_en, strobe_d, wcs_d, addr_read_done;

    // phase decode
    wire t1 = (phase == PH_T1);
    wire t2 = (phase == PH_T2);
    wire t4 = (phase == PH_T4);
    wire ph_end = (ph_cnt == ($bits(ph_cnt))'(dcis_pkg::PHASE_CYC - 1));
    wire fs_lead = FUNCTION_STROBE && !strobe_d;
    wire wcs_trail = wcs_d && !WORD_COUNT_STROBE;
    wire clr_err = ERROR_CLEAR || MASTER_CLEAR;

    // interrupt enable next state: high bits set, low bits hold unless clear bit is high
    wire [2:0] en_bits = OUT_WORD[dcis_pkg::IEN_LO_BIT +: 3];
    wire keep_old = !OUT_WORD[dcis_pkg::IEN_CLR_BIT];
    wire [2:0] next_int_en = en_bits | ({3{keep_old}} & int_en);

    // interrupt sources
    wire ready_pulse = rdy1 && !rdy2 && int_en[0];
    wire eop_int = ((EOP_MARK && CONTROLLER_BUSY) || SET_ALARM_PULSE) && EOP_ENABLE;
    assign SET_ALARM_PULSE = alarm1 && !alarm2;
    wire alarm_int = SET_ALARM_PULSE && int_en[2];
    wire ready_cond = DISK_READY && ON_CYLINDER && !CONTROLLER_BUSY;

    // error gathering
    wire eos_err = END_OF_SECTOR && (stor_par || prot_fault || ck_err || ERR_IN.lost_data);
    wire set_error = (CONTROLLER_BUSY && !DISK_READY) || ctl_seek || ERR_IN.addr_error
        || drv_seek || eos_err;

    // checkword feedback
    wire ck_in = WRITE_CKWD ? 1'b0 : CKWD_SERIAL_IN;
    wire fb = ckwd[11] ^ ck_in;
    wire [11:0] next_ckwd = {ckwd[10:0], 1'b0} ^ ({12{fb}} & dcis_pkg::CKWD_TAPS);
    wire ckwd_zero = (ckwd == dcis_pkg::CKWD_RESET);

    // status selection
    wire [15:0] main_status = {drv_seek, prot_fault, stor_par, SINGLE_DENSITY, ctl_seek,
        ERR_IN.addr_error, ERR_IN.lost_data, ck_err, UNIT_PROTECTED, DATA_MISCOMPARE,
        alarm, EOP_MARK, ON_CYLINDER, intr, CONTROLLER_BUSY, DISK_READY};
    wire [15:0] sel_word = (STATUS_SEL == dcis_pkg::SEL_CKWD) ? {4'h0, ckwd}
        : (STATUS_SEL == dcis_pkg::SEL_MAIN) ? main_status
        : (STATUS_SEL == dcis_pkg::SEL_CWA) ? CURRENT_WORD_ADDR
        : {true_cylinder_addr, 3'h0, SEEK_DONE_OR_ERROR};

    // four-phase sequencer
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            phase <= PH_T1;
            ph_cnt <= '0;
        end else if (CLK_EN) begin
            if (ph_end) begin
                ph_cnt <= '0;
                phase <= dcis_phase_e'(phase + 2'h1);
            end else begin
                ph_cnt <= ph_cnt + 1'b1;
            end
        end
    end

    // edge history of strobes
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            strobe_d <= 1'b0;
            wcs_d <= 1'b0;
        end else if (CLK_EN) begin
            strobe_d <= FUNCTION_STROBE;
            wcs_d <= WORD_COUNT_STROBE;
        end
    end

    // interrupt enable latch
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            int_en <= dcis_pkg::IEN_RESET;
        end else if (CLK_EN) begin
            if (MASTER_CLEAR) begin
                int_en <= dcis_pkg::IEN_RESET;
            end else if (fs_lead) begin
                int_en <= next_int_en;
            end
        end
    end

    // ready-not-busy samplers and interrupt flop
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            rdy1 <= 1'b0;
            rdy2 <= 1'b0;
            intr <= 1'b0;
        end else if (CLK_EN) begin
            if (t1 && ph_end) rdy1 <= ready_cond;
            if (t2 && ph_end) rdy2 <= rdy1;
            if (ready_pulse || eop_int || alarm_int) begin
                intr <= 1'b1;
            end else if (MASTER_CLEAR) begin
                intr <= 1'b0;
            end
        end
    end

    // error and alarm chain
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            err_ff <= 1'b0;
            alarm1 <= 1'b0;
            alarm2 <= 1'b0;
            alarm <= 1'b0;
        end else if (CLK_EN) begin
            if (set_error && !alarm2) begin
                err_ff <= 1'b1;
            end else if (alarm2 || MASTER_CLEAR) begin
                err_ff <= 1'b0;
            end
            if (ph_end) begin
                alarm1 <= err_ff;
                alarm2 <= alarm1;
            end
            if (SET_ALARM_PULSE) begin
                alarm <= 1'b1;
            end else if (clr_err) begin
                alarm <= 1'b0;
            end
        end
    end

    // individual error flops, set wins over clear
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            drv_seek <= 1'b0;
            ctl_seek <= 1'b0;
            prot_fault <= 1'b0;
            stor_par <= 1'b0;
        end else if (CLK_EN) begin
            drv_seek <= ERR_IN.set_drive_seek || (drv_seek && !clr_err);
            ctl_seek <= ERR_IN.set_ctrl_seek || (ctl_seek && !clr_err);
            prot_fault <= (wcs_trail && TRANSFER_CONNECTED && ERR_IN.protect_fault_in)
                || (prot_fault && !clr_err);
            stor_par <= (wcs_trail && TRANSFER_CONNECTED && ERR_IN.storage_parity_in)
                || (stor_par && !clr_err);
        end
    end

    // checkword shifter, error flop and holding register
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            ckwd <= dcis_pkg::CKWD_RESET;
            ck_err <= 1'b0;
            ckwd_hold <= dcis_pkg::CKWD_RESET;
            addr_read_done <= 1'b0;
        end else if (CLK_EN) begin
            if (MASTER_CLEAR) ckwd <= dcis_pkg::CKWD_RESET;
            else if (CKWD_SHIFT) ckwd <= next_ckwd;
            ck_err <= (OP.rd_wr_cc && t2 && SAMPLE_CKWD && !ckwd_zero)
                || (ck_err && !clr_err);
            if (MASTER_CLEAR) ckwd_hold <= dcis_pkg::CKWD_RESET;
            else if (LOAD_CKWD_HOLD) ckwd_hold <= ckwd;
            if (MASTER_CLEAR || !OP.rd_wr_cmp_cc) addr_read_done <= 1'b0;
            else if (ADDR_CKWD_READ) addr_read_done <= 1'b1;
        end
    end

    // cylinder capture
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            tca_en <= 1'b0;
            true_cylinder_addr <= dcis_pkg::TCA_RESET;
        end else if (CLK_EN) begin
            if (MASTER_CLEAR || !OP.rd_wr_cmp_cc) tca_en <= 1'b0;
            else if (UPPER_CYL_TO_SHIFTER) tca_en <= 1'b1;
            if (MASTER_CLEAR) true_cylinder_addr <= dcis_pkg::TCA_RESET;
            else if (tca_en && t4 && ph_end) true_cylinder_addr <= {true_cylinder_addr[7:0], READ_DATA};
        end
    end

    // channel input drivers, inverted, registered
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            CHAN_IN_N <= 16'hffff;
            CHAN_IN_OE <= 1'b0;
        end else if (CLK_EN) begin
            CHAN_IN_N <= ~sel_word;
            CHAN_IN_OE <= CHANNEL_READ && UNIT_SELECTED;
        end
    end

    assign INTERRUPT = intr;
    assign ALARM = alarm;
    assign ADDR_CKWD_ZERO = addr_read_done && ckwd_zero;
    assign CKWD_HOLD = ckwd_hold;
    assign PHASE = phase;

    // assertions
    property p_ien_load;
        @(posedge SYS_CLK) disable iff (!RESETN)
        CLK_EN && fs_lead && !MASTER_CLEAR |=> int_en == $past(next_int_en);
    endproperty
    a_ien_load: assert property (p_ien_load) else $error("enable load wrong");
    property p_ien_hold;
        @(posedge SYS_CLK) disable iff (!RESETN)
        CLK_EN && fs_lead && !MASTER_CLEAR && !OUT_WORD[1] |=> (int_en & ~$past(en_bits))
            == ($past(int_en) & ~$past(en_bits));
    endproperty
    a_ien_hold: assert property (p_ien_hold) else $error("enable hold wrong");
    property p_mc;
        @(posedge SYS_CLK) disable iff (!RESETN)
        CLK_EN && MASTER_CLEAR |=> int_en == 3'h0 && true_cylinder_addr == 9'h000;
    endproperty
    a_mc: assert property (p_mc) else $error("master clear missed");
    property p_alarm_int;
        @(posedge SYS_CLK) disable iff (!RESETN)
        CLK_EN && SET_ALARM_PULSE && int_en[2] |=> INTERRUPT;
    endproperty
    a_alarm_int: assert property (p_alarm_int) else $error("alarm interrupt missed");
    property p_alarm_set;
        @(posedge SYS_CLK) disable iff (!RESETN)
        CLK_EN && SET_ALARM_PULSE |=> ALARM;
    endproperty
    a_alarm_set: assert property (p_alarm_set) else $error("alarm not set");
    property p_err_clr;
        @(posedge SYS_CLK) disable iff (!RESETN)
        CLK_EN && alarm2 && !MASTER_CLEAR |=> !err_ff;
    endproperty
    a_err_clr: assert property (p_err_clr) else $error("error flop kept");
    property p_ckwd_block;
        @(posedge SYS_CLK) disable iff (!RESETN)
        CLK_EN && CKWD_SHIFT && WRITE_CKWD && !MASTER_CLEAR && !ckwd[11]
            |=> ckwd == {$past(ckwd[10:0]), 1'b0};
    endproperty
    a_ckwd_block: assert property (p_ckwd_block) else $error("serial in not blocked");
    property p_ckerr;
        @(posedge SYS_CLK) disable iff (!RESETN)
        CLK_EN && OP.rd_wr_cc && t2 && SAMPLE_CKWD && !ckwd_zero |=> ck_err;
    endproperty
    a_ckerr: assert property (p_ckerr) else $error("checkword error missed");
    property p_hold;
        @(posedge SYS_CLK) disable iff (!RESETN)
        CLK_EN && LOAD_CKWD_HOLD && !MASTER_CLEAR |=> CKWD_HOLD == $past(ckwd);
    endproperty
    a_hold: assert property (p_hold) else $error("holding load wrong");
    property p_drive;
        @(posedge SYS_CLK) disable iff (!RESETN)
        CLK_EN && CHANNEL_READ && UNIT_SELECTED && STATUS_SEL == 2'h0
            |=> CHAN_IN_OE && CHAN_IN_N[15:12] == 4'hf;
    endproperty
    a_drive: assert property (p_drive) else $error("status drive wrong");
    property p_ien_clear;
        @(posedge SYS_CLK) disable iff (!RESETN)
        CLK_EN && fs_lead && !MASTER_CLEAR && OUT_WORD[1] |=> int_en == $past(en_bits);
    endproperty
    a_ien_clear: assert property (p_ien_clear) else $error("enable clear wrong");
    property p_ready_smp;
        @(posedge SYS_CLK) disable iff (!RESETN)
        CLK_EN && t1 && ph_end |=> rdy1 == $past(ready_cond);
    endproperty
    a_ready_smp: assert property (p_ready_smp) else $error("ready sample wrong");
    property p_ready_int;
        @(posedge SYS_CLK) disable iff (!RESETN)
        CLK_EN && ready_pulse |=> INTERRUPT;
    endproperty
    a_ready_int: assert property (p_ready_int) else $error("ready interrupt missed");
    property p_eop_int;
        @(posedge SYS_CLK) disable iff (!RESETN)
        CLK_EN && EOP_MARK && CONTROLLER_BUSY && EOP_ENABLE |=> INTERRUPT;
    endproperty
    a_eop_int: assert property (p_eop_int) else $error("end interrupt missed");
    property p_err_set;
        @(posedge SYS_CLK) disable iff (!RESETN)
        CLK_EN && (drv_seek || ctl_seek) && !alarm2 |=> err_ff;
    endproperty
    a_err_set: assert property (p_err_set) else $error("error flop missed");
    property p_seek_err;
        @(posedge SYS_CLK) disable iff (!RESETN)
        CLK_EN && ERR_IN.set_drive_seek |=> drv_seek;
    endproperty
    a_seek_err: assert property (p_seek_err) else $error("seek error missed");
    property p_prot;
        @(posedge SYS_CLK) disable iff (!RESETN)
        CLK_EN && wcs_trail && TRANSFER_CONNECTED && ERR_IN.protect_fault_in |=> prot_fault;
    endproperty
    a_prot: assert property (p_prot) else $error("protect fault missed");
    property p_acz;
        @(posedge SYS_CLK) disable iff (!RESETN)
        CLK_EN && ADDR_CKWD_READ && OP.rd_wr_cmp_cc && !MASTER_CLEAR && !CKWD_SHIFT
            && ckwd_zero |=> ADDR_CKWD_ZERO;
    endproperty
    a_acz: assert property (p_acz) else $error("address checkword zero missed");
    property p_tca;
        @(posedge SYS_CLK) disable iff (!RESETN)
        CLK_EN && tca_en && t4 && ph_end && !MASTER_CLEAR
            |=> true_cylinder_addr == {$past(true_cylinder_addr[7:0]), $past(READ_DATA)};
    endproperty
    a_tca: assert property (p_tca) else $error("cylinder shift wrong");
    property p_seek_word;
        @(posedge SYS_CLK) disable iff (!RESETN)
        CLK_EN && CHANNEL_READ && UNIT_SELECTED && STATUS_SEL == dcis_pkg::SEL_SEEK
            |=> CHAN_IN_N[6:4] == 3'h7;
    endproperty
    a_seek_word: assert property (p_seek_word) else $error("seek word zeros wrong");
    c_ready: cover property (@(posedge SYS_CLK) disable iff (!RESETN) ready_pulse);
    c_alarm: cover property (@(posedge SYS_CLK) disable iff (!RESETN) SET_ALARM_PULSE);
    c_tca: cover property (@(posedge SYS_CLK) disable iff (!RESETN) tca_en && t4);
    c_eop: cover property (@(posedge SYS_CLK) disable iff (!RESETN) eop_int);
    c_acz: cover property (@(posedge SYS_CLK) disable iff (!RESETN) ADDR_CKWD_ZERO);

endmodule : dcis_core

// File: testbench/dcis_host.sv
`timescale 1ns/100ps
// host channel model: issues function words and status reads on the falling edge
module dcis_host (
    input wire logic SYS_CLK,
    output logic FUNCTION_STROBE,
    output logic [15:0] OUT_WORD,
    output logic [1:0] STATUS_SEL,
    output logic CHANNEL_READ,
    output logic UNIT_SELECTED,
    input wire logic [15:0] CHAN_IN_N,
    input wire logic CHAN_IN_OE
);
    // idle channel at time zero
    initial begin
        {FUNCTION_STROBE, CHANNEL_READ, UNIT_SELECTED} = '0;
        OUT_WORD = 16'h0000;
        STATUS_SEL = 2'h0;
    end

    // one strobe per output word; the released bus shows the inverse afterwards
    task automatic put_word(input logic [15:0] wd);
        @(negedge SYS_CLK);
        OUT_WORD = wd;
        FUNCTION_STROBE = 1'b1;
        @(negedge SYS_CLK);
        FUNCTION_STROBE = 1'b0;
        @(negedge SYS_CLK);
        OUT_WORD = ~wd;
    endtask : put_word

    // status read held past the one-cycle lag of the drivers
    task automatic get_word(input logic [1:0] sel, input logic en, output logic [15:0] wd,
                            output logic oe);
        @(negedge SYS_CLK);
        STATUS_SEL = sel;
        CHANNEL_READ = 1'b1;
        UNIT_SELECTED = en;
        repeat (2) @(negedge SYS_CLK);
        wd = ~CHAN_IN_N;
        oe = CHAN_IN_OE;
        {CHANNEL_READ, UNIT_SELECTED} = '0;
        STATUS_SEL = ~sel;
    endtask : get_word
endmodule : dcis_host

// File: testbench/dcis_core_tb_top.sv
`timescale 1ns/100ps
// drives drive-side and checkword inputs; the host model owns the channel
module dcis_core_tb_top;
    logic sys_clk, resetn, master_clear, error_clear, disk_ready, on_cyl, ctrl_busy;
    logic eop_mark, eop_enable, eos, xfer_conn, wc_strobe, ckwd_shift, ckwd_in;
    logic write_ckwd, sample_ckwd, addr_ckwd_read, load_hold, upper_cyl, read_data;
    logic fn_strobe, chan_read, unit_sel, chan_oe, intr, alarm, oe;
    logic [1:0] status_sel;
    logic [3:0] seek;
    logic [15:0] out_word, chan_in_n, w, cwa;
    logic [11:0] ckwd_hold, exp_ck;
    dcis_pkg::dcis_err_s err_in;
    dcis_pkg::dcis_op_s op;
    int err_total, tests_run;
    logic clk_en, miscmp, uprot, sdens, set_pulse, acz;
    logic [1:0] phase, ph;

    dcis_core i_dcis_core (
        .SYS_CLK(sys_clk), .RESETN(resetn), .CLK_EN(clk_en), .MASTER_CLEAR(master_clear),
        .ERROR_CLEAR(error_clear), .FUNCTION_STROBE(fn_strobe), .OUT_WORD(out_word),
        .DISK_READY(disk_ready), .ON_CYLINDER(on_cyl), .CONTROLLER_BUSY(ctrl_busy),
        .EOP_MARK(eop_mark), .EOP_ENABLE(eop_enable), .END_OF_SECTOR(eos),
        .TRANSFER_CONNECTED(xfer_conn), .WORD_COUNT_STROBE(wc_strobe), .ERR_IN(err_in),
        .OP(op), .CKWD_SHIFT(ckwd_shift), .CKWD_SERIAL_IN(ckwd_in), .WRITE_CKWD(write_ckwd),
        .SAMPLE_CKWD(sample_ckwd), .ADDR_CKWD_READ(addr_ckwd_read), .LOAD_CKWD_HOLD(load_hold),
        .UPPER_CYL_TO_SHIFTER(upper_cyl), .READ_DATA(read_data), .DATA_MISCOMPARE(miscmp),
        .UNIT_PROTECTED(uprot), .SINGLE_DENSITY(sdens), .CURRENT_WORD_ADDR(cwa),
        .SEEK_DONE_OR_ERROR(seek), .STATUS_SEL(status_sel), .CHANNEL_READ(chan_read),
        .UNIT_SELECTED(unit_sel), .INTERRUPT(intr), .ALARM(alarm), .SET_ALARM_PULSE(set_pulse),
        .ADDR_CKWD_ZERO(acz), .CKWD_HOLD(ckwd_hold), .PHASE(phase), .CHAN_IN_N(chan_in_n),
        .CHAN_IN_OE(chan_oe));

    dcis_host i_dcis_host (.SYS_CLK(sys_clk), .FUNCTION_STROBE(fn_strobe), .OUT_WORD(out_word),
        .STATUS_SEL(status_sel), .CHANNEL_READ(chan_read), .UNIT_SELECTED(unit_sel),
        .CHAN_IN_N(chan_in_n), .CHAN_IN_OE(chan_oe));

    // 100 ns clock
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic idle(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : idle

    // selected status read, masked
    task automatic rd(input logic [1:0] sel, input logic [15:0] mask);
        i_dcis_host.get_word(sel, 1'b1, w, oe);
        check({15'h0, oe}, 16'h0001);
        w = w & mask;
    endtask : rd

    task automatic mclr();
        idle(1);
        master_clear = 1'b1;
        idle(1);
        master_clear = 1'b0;
        idle(2);
    endtask : mclr

    // one serial bit into the checkword and into the reference copy
    task automatic shift_in(input logic b);
        logic fb;
        @(negedge sys_clk);
        ckwd_in = b;
        ckwd_shift = 1'b1;
        fb = exp_ck[11] ^ (b & ~write_ckwd);
        exp_ck = {exp_ck[10:0], 1'b0} ^ ({12{fb}} & dcis_pkg::CKWD_TAPS);
        @(negedge sys_clk);
        ckwd_shift = 1'b0;
    endtask : shift_in

    task automatic final_report();
        $display("checks=%0d mismatches=%0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report

    // watchdog
    initial begin
        #400000;
        err_total++;
        final_report();
    end

    initial begin
        {master_clear, error_clear, disk_ready, ctrl_busy, eop_mark, eop_enable} = '0;
        {eos, xfer_conn, wc_strobe, ckwd_shift, ckwd_in, write_ckwd} = '0;
        {sample_ckwd, addr_ckwd_read, load_hold, upper_cyl, read_data, resetn} = '0;
        err_in = '0;
        op = '0;
        on_cyl = 1'b1;
        {miscmp, uprot, sdens} = '0;
        clk_en = 1'b1;
        cwa = 16'ha5c3;
        seek = 4'h9;
        exp_ck = 12'h000;
        err_total = 0;
        tests_run = 0;
        idle(2);
        resetn = 1'b1;
        // each select code after reset, then an unselected read
        rd(2'h0, 16'hffff);
        check(w, 16'h0000);
        rd(2'h2, 16'hffff);
        check(w, 16'ha5c3);
        rd(2'h3, 16'hffff);
        check(w, 16'h0009);
        {miscmp, uprot, sdens} = 3'h7;
        rd(2'h1, 16'h10c0);
        check(w, 16'h10c0);
        {miscmp, uprot, sdens} = 3'h0;
        i_dcis_host.get_word(2'h1, 1'b0, w, oe);
        check({15'h0, oe}, 16'h0000);
        // clear-lows load drops every enable, so ready raises nothing
        i_dcis_host.put_word(16'h001e);
        i_dcis_host.put_word(16'h0002);
        disk_ready = 1'b1;
        idle(8);
        check({15'h0, intr}, 16'h0000);
        disk_ready = 1'b0;
        // ready enable set, then kept through a hold-mode load
        i_dcis_host.put_word(16'h0004);
        i_dcis_host.put_word(16'h0000);
        idle(4);
        disk_ready = 1'b1;
        idle(8);
        check({15'h0, intr}, 16'h0001);
        rd(2'h1, 16'h0004);
        check(w, 16'h0004);
        rd(2'h1, 16'h0004);
        check(w, 16'h0004);
        disk_ready = 1'b0;
        mclr();
        check({15'h0, intr}, 16'h0000);
        disk_ready = 1'b1;
        idle(8);
        check({15'h0, intr}, 16'h0000);
        // end of operation with its enable
        i_dcis_host.put_word(16'h0008);
        {ctrl_busy, eop_enable, eop_mark} = 3'h7;
        idle(4);
        check({15'h0, intr}, 16'h0001);
        {ctrl_busy, eop_enable, eop_mark} = 3'h0;
        mclr();
        // seek and protect errors latch; the seek error raises the alarm and its interrupt
        i_dcis_host.put_word(16'h0010);
        {err_in.set_drive_seek, err_in.protect_fault_in, xfer_conn, wc_strobe} = 4'hf;
        idle(1);
        wc_strobe = 1'b0;
        idle(1);
        err_in = '0;
        idle(1);
        check({15'h0, set_pulse}, 16'h0001);
        idle(1);
        check({15'h0, set_pulse}, 16'h0000);
        idle(6);
        xfer_conn = 1'b0;
        check({14'h0, alarm, intr}, 16'h0003);
        rd(2'h1, 16'hc020);
        check(w, 16'hc020);
        // the alarm chain still carries one error; hold the clear until it has passed
        error_clear = 1'b1;
        idle(8);
        error_clear = 1'b0;
        idle(2);
        rd(2'h1, 16'hc020);
        check(w, 16'h0000);
        check({15'h0, intr}, 16'h0001);
        // phases advance one per cycle; a low clock enable freezes all state
        ph = phase;
        idle(1);
        check({14'h0, phase}, {14'h0, ph + 2'h1});
        clk_en = 1'b0;
        ph = phase;
        mclr();
        check({13'h0, phase, intr}, {13'h0, ph, 1'b1});
        clk_en = 1'b1;
        mclr();
        // sixteen serial bits, the last four with the input blocked
        w = 16'hb35a;
        for (int i = 15; i >= 0; i--) begin
            write_ckwd = (i < 4);
            shift_in(w[i]);
        end
        write_ckwd = 1'b0;
        rd(2'h0, 16'hffff);
        check(w, {4'h0, exp_ck});
        load_hold = 1'b1;
        idle(1);
        load_hold = 1'b0;
        idle(1);
        check({4'h0, ckwd_hold}, {4'h0, exp_ck});
        op.rd_wr_cc = 1'b1;
        sample_ckwd = 1'b1;
        idle(4);
        sample_ckwd = 1'b0;
        op = '0;
        rd(2'h1, 16'h0100);
        check(w, (exp_ck != 12'h000) ? 16'h0100 : 16'h0000);
        // lost data at end of sector raises the alarm
        {err_in.lost_data, eos} = 2'h3;
        idle(1);
        {err_in.lost_data, eos} = 2'h0;
        idle(6);
        check({15'h0, alarm}, 16'h0001);
        mclr();
        check({4'h0, ckwd_hold}, 16'h0000);
        // cylinder capture from a run of ones on the read data line
        op.rd_wr_cmp_cc = 1'b1;
        addr_ckwd_read = 1'b1;
        idle(1);
        addr_ckwd_read = 1'b0;
        check({15'h0, acz}, 16'h0001);
        {upper_cyl, read_data} = 2'h3;
        idle(40);
        rd(2'h3, 16'hffff);
        check(w, 16'hff89);
        shift_in(1'b1);
        check({15'h0, acz}, 16'h0000);
        {upper_cyl, read_data} = 2'h0;
        op = '0;
        final_report();
    end
endmodule : dcis_core_tb_top
